// File: design/adc_ctrl_defines.svh
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

// Conversion time in ns and oscillator cycles
`define CONV_TIME_NS 880
`define CLK_PERIOD_NS 100
// Longest time rounds down
`define CONV_CYCLES ((`CONV_TIME_NS) / (`CLK_PERIOD_NS))
// Wake-up times in us
`define WAKE_PARTIAL_US 20
`define WAKE_FULL_US 500
`define WAKE_PARTIAL_CYCLES ((`WAKE_PARTIAL_US * 1000) / (`CLK_PERIOD_NS))
`define WAKE_FULL_CYCLES ((`WAKE_FULL_US * 1000) / (`CLK_PERIOD_NS))
`define RESULT_WIDTH 12
`define RESULT_RESET 12'h000
`define CNT_WIDTH 16

`endif

// File: design/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
  typedef enum logic [2:0] {
    ST_TRACK = 3'b000,
    ST_CONVERT = 3'b001,
    ST_SLEEP = 3'b010,
    ST_WAKE = 3'b011
  } conv_state_t;
endpackage

// File: design/parallel_adc_conversion_control.sv
`include "adc_ctrl_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module parallel_adc_conversion_control #(
  parameter int unsigned WAKE_PARTIAL_CYCLES = `WAKE_PARTIAL_CYCLES,
  parameter int unsigned WAKE_FULL_CYCLES = `WAKE_FULL_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic conversion_start_n_in,
  input wire logic chip_select_n_in,
  input wire logic read_n_in,
  input wire logic sleep_type_select_in,
  input wire logic [`RESULT_WIDTH-1:0] sample_data_in,
  output logic [`RESULT_WIDTH-1:0] result_bus_out,
  output logic [`RESULT_WIDTH-1:0] result_bus_oe_n_out,
  output logic busy_out,
  output logic hold_out,
  output logic asleep_out,
  output logic full_sleep_out,
  output var adc_ctrl_pkg::conv_state_t state_out
);
  import adc_ctrl_pkg::*;

  // ****************************************
  // Timing constants
  // ****************************************
  // Last count of a conversion; the oscillator count is fixed
  localparam logic [`CNT_WIDTH-1:0] CONV_LAST = `CNT_WIDTH'(`CONV_CYCLES - 1);

  // Result capture point, one cycle ahead of the last count
  localparam logic [`CNT_WIDTH-1:0] LOAD_POINT = `CNT_WIDTH'(`CONV_CYCLES - 2);

  // Last count of each wake-up settling time
  localparam logic [`CNT_WIDTH-1:0] WAKE_PARTIAL_LAST = `CNT_WIDTH'(WAKE_PARTIAL_CYCLES - 1);
  localparam logic [`CNT_WIDTH-1:0] WAKE_FULL_LAST = `CNT_WIDTH'(WAKE_FULL_CYCLES - 1);

  // ****************************************
  // Helper functions
  // ****************************************
  // Settling length depends on the sleep type latched at entry
  function automatic logic [`CNT_WIDTH-1:0] wake_last(input logic full_sel);
    if (full_sel) begin
      return WAKE_FULL_LAST;
    end
    return WAKE_PARTIAL_LAST;
  endfunction

  function automatic logic [`CNT_WIDTH-1:0] count_up(input logic [`CNT_WIDTH-1:0] value);
    return value + `CNT_WIDTH'(1);
  endfunction

  // A start is honoured while tracking or while settling after wake-up
  function automatic logic start_allowed(input conv_state_t state);
    return (state == ST_TRACK) || (state == ST_WAKE);
  endfunction

  // ****************************************
  // Internal signals
  // ****************************************
  conv_state_t state_reg;
  logic start_n_d_reg;
  logic [`CNT_WIDTH-1:0] cnt_reg;
  logic [`RESULT_WIDTH-1:0] result_reg;
  logic full_sel_reg;
  logic start_fall;
  logic start_rise;
  logic start_accept;
  logic conv_done;
  logic wake_done;
  logic sleep_request;
  logic read_en;

  // ****************************************
  // Start strobe edge detection
  // ****************************************
  // Resets to the idle high level so leaving reset with the strobe high never looks like a rising edge
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      start_n_d_reg <= 1'b1;
    end else begin
      start_n_d_reg <= conversion_start_n_in;
    end
  end

  assign start_fall = start_n_d_reg & ~conversion_start_n_in;
  assign start_rise = ~start_n_d_reg & conversion_start_n_in;

  // Falls during a conversion or in sleep are ignored
  assign start_accept = start_fall && start_allowed(state_reg);

  // ****************************************
  // Sequencing decodes
  // ****************************************
  // Fixed oscillator count; no clock comes from outside
  assign conv_done = (state_reg == ST_CONVERT) && (cnt_reg == CONV_LAST);

  // Strobe still low at the end of a conversion asks for sleep
  assign sleep_request = conv_done && !conversion_start_n_in;

  // Settling only; a start during wake-up wins but may sample inaccurately
  assign wake_done = (state_reg == ST_WAKE) && !start_fall
    && (cnt_reg >= wake_last(full_sel_reg));

  // ****************************************
  // Conversion and sleep state
  // ****************************************
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state_reg <= ST_TRACK;
    end else begin
      unique case (state_reg)
        ST_TRACK: begin
          if (start_accept) begin
            state_reg <= ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          if (sleep_request) begin
            state_reg <= ST_SLEEP;
          end else if (conv_done) begin
            state_reg <= ST_TRACK;
          end
        end
        ST_SLEEP: begin
          if (start_rise) begin
            state_reg <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (start_accept) begin
            state_reg <= ST_CONVERT;
          end else if (wake_done) begin
            state_reg <= ST_TRACK;
          end
        end
        default: begin
          state_reg <= ST_TRACK;
        end
      endcase
    end
  end

  // ****************************************
  // Cycle counter
  // ****************************************
  // One counter serves conversion and wake-up; the two never overlap
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      cnt_reg <= '0;
    end else if (start_accept || conv_done || wake_done) begin
      cnt_reg <= '0;
    end else if (state_reg == ST_CONVERT || state_reg == ST_WAKE) begin
      cnt_reg <= count_up(cnt_reg);
    end
  end

  // ****************************************
  // Sleep type latch
  // ****************************************
  // The strap is read once at sleep entry, so a late change cannot alter a sleep in progress
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      full_sel_reg <= 1'b0;
    end else if (sleep_request) begin
      full_sel_reg <= sleep_type_select_in;
    end
  end

  // ****************************************
  // Output register
  // ****************************************
  // Loaded one cycle before busy falls, so a read after busy sees the new sample
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      result_reg <= `RESULT_RESET;
    end else if (state_reg == ST_CONVERT && cnt_reg == LOAD_POINT) begin
      result_reg <= sample_data_in;
    end
  end

  // ****************************************
  // Track/hold control
  // ****************************************
  // Track returns with the last conversion cycle, just ahead of busy
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      hold_out <= 1'b0;
    end else begin
      hold_out <= start_accept || (state_reg == ST_CONVERT && cnt_reg < LOAD_POINT);
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  // Select and read pass one AND gate, so either may assert last
  assign read_en = ~chip_select_n_in & ~read_n_in;

  assign result_bus_out = result_reg;
  assign result_bus_oe_n_out = {`RESULT_WIDTH{~read_en}};

  // ****************************************
  // Status outputs
  // ****************************************
  assign busy_out = (state_reg == ST_CONVERT);
  assign asleep_out = (state_reg == ST_SLEEP);
  assign full_sleep_out = (state_reg == ST_SLEEP) && full_sel_reg;
  assign state_out = state_reg;
endmodule

`default_nettype wire

// File: dv/adc_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_monitor #(parameter int WAKE_FULL_CYCLES = 8) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic conversion_start_n_in,
  input wire logic chip_select_n_in,
  input wire logic read_n_in,
  input wire logic [11:0] result_bus_out,
  input wire logic [11:0] result_bus_oe_n_out,
  input wire logic busy_out,
  input wire logic hold_out,
  input wire logic asleep_out,
  input wire logic [2:0] state_out
);
  localparam int WAIT_MAX = WAKE_FULL_CYCLES + 2;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  chk_oe_gate: assert property (result_bus_oe_n_out == {12{chip_select_n_in | read_n_in}}) else $error("oe");
  chk_busy_len: assert property ($fell(conversion_start_n_in) && state_out inside {3'h0, 3'h3}
    |=> busy_out [*8] ##1 !busy_out) else $error("busy len");
  chk_hold_busy: assert property (hold_out |-> busy_out) else $error("hold");
  chk_hold_start: assert property ($rose(busy_out) |-> hold_out) else $error("hold start");
  chk_track_first: assert property ($fell(busy_out) |-> !$past(hold_out)) else $error("track");
  chk_result_ready: assert property ($fell(busy_out) |-> $stable(result_bus_out)) else $error("res");
  chk_sleep_entry: assert property ($fell(busy_out) |-> asleep_out == !$past(conversion_start_n_in))
    else $error("sleep");
  chk_wake_edge: assert property (asleep_out && $rose(conversion_start_n_in) |=> state_out == 3'h3)
    else $error("wake");
  chk_wake_end: assert property ($fell(asleep_out) |-> ##[1:WAIT_MAX] state_out != 3'h3) else $error("wake end");
  cover property ($fell(busy_out));
  cover property ($rose(asleep_out));
  cover property ($fell(asleep_out));
endmodule
bind parallel_adc_conversion_control adc_ctrl_monitor #(.WAKE_FULL_CYCLES(WAKE_FULL_CYCLES)) u_mon (
  .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .conversion_start_n_in(conversion_start_n_in),
  .chip_select_n_in(chip_select_n_in), .read_n_in(read_n_in), .result_bus_out(result_bus_out),
  .result_bus_oe_n_out(result_bus_oe_n_out), .busy_out(busy_out), .hold_out(hold_out),
  .asleep_out(asleep_out), .state_out(state_out));
`default_nettype wire

// File: dv/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input wire logic clk_in,
  input wire logic [11:0] drive_in,
  input wire logic [11:0] oe_n_in,
  output logic [11:0] wire_out
);
  logic [11:0] last_reg = 12'h000;
  always @(posedge clk_in) last_reg <= wire_out;
  // Released lines flip each cycle so a stale result never reads as fresh
  assign wire_out = (drive_in & ~oe_n_in) | (~last_reg & oe_n_in);
endmodule
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 0, rst = 1, st_n = 1, cs_n = 1, rd_n = 1, ps = 0, busy, hold, slp, fs;
  logic [11:0] smp = 12'h000, bus, oe_n, wire_v;
  logic [2:0] st;
  logic [2:0] rows [4] = '{3'b111, 3'b011, 3'b101, 3'b000};
  int num_errors = 0, n_checks = 0, n;
  parallel_adc_conversion_control #(.WAKE_PARTIAL_CYCLES(4), .WAKE_FULL_CYCLES(8)) DUT (
    .sys_clk_in(clk), .sys_rst_in(rst), .conversion_start_n_in(st_n), .chip_select_n_in(cs_n),
    .read_n_in(rd_n), .sleep_type_select_in(ps), .sample_data_in(smp), .result_bus_out(bus),
    .result_bus_oe_n_out(oe_n), .busy_out(busy), .hold_out(hold), .asleep_out(slp),
    .full_sleep_out(fs), .state_out(st));
  host_bus_model host (.clk_in(clk), .drive_in(bus), .oe_n_in(oe_n), .wire_out(wire_v));
  initial forever #50 clk = ~clk;
  task automatic chk(logic ok);
    n_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("unexpected %0t mismatch", $time);
    end
  endtask
  // Start strobe held one cycle, or kept low to request sleep
  task automatic conv(logic low, logic [11:0] v);
    @(posedge clk);
    smp <= v;
    st_n <= 0;
    @(posedge clk);
    if (!low) st_n <= 1;
    repeat (7) @(posedge clk);
    #1 chk(busy === 1'b1 && hold === 1'b0 && wire_v === v);
    @(posedge clk);
    #1 chk(busy === 1'b0);
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic end_sim;
    if (num_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    #1 chk(busy === 1'b0 && hold === 1'b0 && slp === 1'b0 && st === 3'h0 && bus === 12'h000);
    foreach (rows[i]) begin
      @(posedge clk);
      cs_n <= rows[i][2];
      rd_n <= rows[i][1];
      #1 chk(oe_n === {12{rows[i][0]}});
    end
    conv(0, 12'h5a3);
    chk(wire_v === 12'h5a3 && slp === 1'b0);
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      ps <= p[0];
      conv(1, 12'ha5c);
      chk(slp === 1'b1 && fs === p[0] && wire_v === 12'ha5c);
      @(posedge clk);
      st_n <= 1;
      n = 0;
      @(posedge clk);
      #1;
      while (st !== 3'h0 && n < 20) begin
        @(posedge clk);
        #1 n++;
      end
      chk(n == (p ? 8 : 4));
    end
    end_sim();
  end
  initial begin
    #50000;
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
